//--- fslp_pkg.sv
// fslp_pkg: constants and types shared by the lock protection files
// assumes a 64MB array of 1024 blocks of 64KB, 4KB sectors, 4-byte addressing
package fslp_pkg;
	// command opcodes seen on the serial link
	localparam logic [7:0] OP_WRITE_ENABLE   = 8'h06;
	localparam logic [7:0] OP_WRITE_DISABLE  = 8'h04;
	localparam logic [7:0] OP_READ_VOL       = 8'he0;
	localparam logic [7:0] OP_WRITE_VOL      = 8'he1;
	localparam logic [7:0] OP_READ_PERS      = 8'he2;
	localparam logic [7:0] OP_SET_PERS       = 8'he3;
	localparam logic [7:0] OP_CLEAR_PERS     = 8'he4;
	localparam logic [7:0] OP_VOL_UNLOCK_ALL = 8'h98;
	localparam logic [7:0] OP_VOL_LOCK_ALL   = 8'h7e;

	// array geometry and region map
	localparam int               ADDR_W          = 26;
	localparam int               LOCK_W          = 8;
	localparam int               IDX_W           = 11;
	localparam int               REGION_COUNT    = 1054;
	localparam int               BLOCK_LSB       = 16;
	localparam int               SECTOR_LSB      = 12;
	localparam logic [IDX_W-1:0] IDX_LAST        = 11'h41d;
	localparam logic [9:0]       BLOCK_FIRST     = 10'h000;
	localparam logic [9:0]       BLOCK_LAST      = 10'h3ff;
	localparam logic [10:0]      BLOCK_TOTAL     = 11'h400;
	localparam logic [IDX_W-1:0] TOP_SECTOR_BASE = 11'h010;
	localparam logic [IDX_W-1:0] MID_BLOCK_BASE  = 11'h01f;

	// lock register values
	localparam logic [LOCK_W-1:0] LOCK_SET = 8'hff;
	localparam logic [LOCK_W-1:0] LOCK_CLR = 8'h00;

	// position of the volatile lock default in configuration byte 2
	localparam int CFG_VL_DEFAULT_BIT = 2;

	// range-protect codes
	localparam logic [3:0] RANGE_NONE       = 4'h0;
	localparam logic [3:0] RANGE_ONE        = 4'h1;
	localparam logic [3:0] RANGE_LAST_SIZED = 4'ha;

	// frame bit counts, value of the bit counter at the last bit of each field, then the value where the counter stops
	localparam logic [5:0] FRM_OPCODE_END = 6'h07;
	localparam logic [5:0] FRM_ADDR_END   = 6'h27;
	localparam logic [5:0] FRM_DATA_END   = 6'h2f;
	localparam logic [5:0] FRM_OUT_END    = 6'h37;
	localparam logic [5:0] FRM_CNT_MAX    = 6'h3f;

	// core sequencer states
	typedef enum logic [1:0] {
		ST_IDLE   = 2'b00,
		ST_FETCH  = 2'b01,
		ST_RESULT = 2'b10,
		ST_SWEEP  = 2'b11
	} fslp_state_type;
endpackage

//--- fslp_sync2.sv
// fslp_sync2: two flip-flop level synchroniser
// assumes d_i is a level or toggle that stays put for at least two clk_i edges
`timescale 1ns/1ps
module fslp_sync2 (
	input  wire logic clk_i,   // destination clock
	input  wire logic rst_n_i, // async reset, active low
	input  wire logic d_i,     // level from another domain
	output logic      q_o      // synchronised level
);
	logic meta_q;

	// first stage feeds only the second stage
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			meta_q <= 1'b0;
			q_o    <= 1'b0;
		end else begin
			meta_q <= d_i;
			q_o    <= meta_q;
		end
	end
endmodule

//--- fslp_lock_mem.sv
// fslp_lock_mem: one bank of per-region lock registers, one write and one read port
// assumes addresses below the region count; contents survive reset, read data is registered
`timescale 1ns/1ps
module fslp_lock_mem (
	input  wire logic                         clk_i,     // core clock
	input  wire logic                         wr_en_i,   // write strobe
	input  wire logic [fslp_pkg::IDX_W-1:0]   wr_addr_i, // region written
	input  wire logic [fslp_pkg::LOCK_W-1:0]  wr_data_i, // value written
	input  wire logic [fslp_pkg::IDX_W-1:0]   rd_addr_i, // region read
	output logic      [fslp_pkg::LOCK_W-1:0]  rd_data_o  // data one edge after rd_addr_i
);
	logic [fslp_pkg::LOCK_W-1:0] mem_q [0:fslp_pkg::REGION_COUNT-1];

	// shipped state: every region unlocked
	initial begin
		for (int i = 0; i < fslp_pkg::REGION_COUNT; i++) begin
			mem_q[i] = fslp_pkg::LOCK_CLR;
		end
	end

	// no reset on purpose: the persistent bank must keep its values
	always_ff @(posedge clk_i) begin
		if (wr_en_i) begin
			mem_q[wr_addr_i] <= wr_data_i;
		end
		rd_data_o <= mem_q[rd_addr_i];
	end
endmodule

//--- fslp_lock_protect.sv
// fslp_lock_protect: range decode plus volatile and persistent region locks
// assumes a host on the serial link (mode 0, msb first) and an array controller
// on ref_clk_i that asks for program/erase clearance with check_req_i
`timescale 1ns/1ps
module fslp_lock_protect (
	input  wire logic                               ref_clk_i,                 // core clock
	input  wire logic                               resetn_i,                  // async reset, low
	input  wire logic                               link_clk_i,                // serial clock
	input  wire logic                               cs_n_i,                    // chip select, low
	input  wire logic                               si_i,                      // serial data in
	output logic                                    so_o,                      // serial data out
	output logic                                    so_oe_o,                   // so_o driven
	input  wire logic                               range_protect_top_bit_i,   // range at bottom
	input  wire logic [3:0]                         range_protect_code_i,      // range size code
	input  wire logic                               complement_protect_i,      // invert range
	input  wire logic                               status_protect_select_i,   // pin lock mode
	input  wire logic                               wp_n_i,                    // write protect pin
	input  wire logic [7:0]                         persistent_config_byte2_i, // config byte 2
	input  wire logic                               check_req_i,               // clearance request
	input  wire logic [fslp_pkg::ADDR_W-1:0]        check_addr_i,              // target byte address
	output logic                                    check_done_o,              // clearance ready
	output logic                                    check_allowed_o,           // program/erase ok
	output logic                                    write_enable_latch_o,      // latch state
	output logic                                    status_write_blocked_o,    // status writes locked
	output logic                                    busy_o                     // sequencer busy
);
	// region index of a byte address: 16 bottom sectors, 16 top sectors, then blocks
	function automatic logic [fslp_pkg::IDX_W-1:0] region_index(
		input logic [fslp_pkg::ADDR_W-1:0] addr);
		logic [9:0] blk;
		logic [3:0] sec;
		blk = addr[fslp_pkg::ADDR_W-1:fslp_pkg::BLOCK_LSB];
		sec = addr[fslp_pkg::BLOCK_LSB-1:fslp_pkg::SECTOR_LSB];
		if (blk == fslp_pkg::BLOCK_FIRST) begin
			region_index = {7'h00, sec};
		end else if (blk == fslp_pkg::BLOCK_LAST) begin
			region_index = fslp_pkg::TOP_SECTOR_BASE + {7'h00, sec};
		end else begin
			region_index = fslp_pkg::MID_BLOCK_BASE + {1'b0, blk};
		end
	endfunction

	// range-protect decode: plain table, then complemented by the complement bit
	function automatic logic range_hit(
		input logic [9:0] blk,
		input logic       top,
		input logic [3:0] code,
		input logic       cmp);
		logic [10:0] span;
		logic        base;
		span = 11'h001 << (code - fslp_pkg::RANGE_ONE);
		if (code == fslp_pkg::RANGE_NONE) begin
			base = 1'b0;
		end else if (code > fslp_pkg::RANGE_LAST_SIZED) begin
			base = 1'b1;
		end else if (top) begin
			base = ({1'b0, blk} < span);
		end else begin
			base = ({1'b0, blk} >= (fslp_pkg::BLOCK_TOTAL - span));
		end
		range_hit = base ^ cmp;
	endfunction

	// ---------------- link domain ----------------
	logic                         frame_rst_n;
	logic [5:0]                   lnk_cnt_q;
	logic [33:0]                  lnk_sh_q;
	logic [33:0]                  lnk_sh_d;
	logic [7:0]                   lnk_op_q;
	logic [7:0]                   lnk_op_now;
	logic                         lnk_ev;
	logic                         lnk_is_read;
	logic [7:0]                   lnk_out_q;
	logic                         lnk_oe_q;
	logic                         lnk_req_tgl_q;
	logic                         lnk_ack_s;
	logic [7:0]                   hold_op_q;
	logic [fslp_pkg::ADDR_W-1:0]  hold_addr_q;
	logic [7:0]                   hold_data_q;
	logic [7:0]                   rdata_q;       // core reply, read here only after the ack

	// a raised chip select ends the frame without needing a clock edge
	assign frame_rst_n = resetn_i & ~cs_n_i;
	assign lnk_sh_d    = {lnk_sh_q[32:0], si_i};
	assign lnk_op_now  = (lnk_cnt_q == fslp_pkg::FRM_OPCODE_END) ? lnk_sh_d[7:0] : lnk_op_q;
	assign lnk_is_read = (lnk_op_q == fslp_pkg::OP_READ_VOL) |
	                     (lnk_op_q == fslp_pkg::OP_READ_PERS);

	// a command is handed over as soon as its last needed bit arrives
	always_comb begin
		lnk_ev = 1'b0;
		case (lnk_cnt_q)
			fslp_pkg::FRM_OPCODE_END: begin
				lnk_ev = (lnk_op_now == fslp_pkg::OP_WRITE_ENABLE) |
				         (lnk_op_now == fslp_pkg::OP_WRITE_DISABLE) |
				         (lnk_op_now == fslp_pkg::OP_VOL_UNLOCK_ALL) |
				         (lnk_op_now == fslp_pkg::OP_VOL_LOCK_ALL) |
				         (lnk_op_now == fslp_pkg::OP_CLEAR_PERS);
			end
			fslp_pkg::FRM_ADDR_END: begin
				lnk_ev = lnk_is_read | (lnk_op_q == fslp_pkg::OP_SET_PERS);
			end
			fslp_pkg::FRM_DATA_END: begin
				lnk_ev = (lnk_op_q == fslp_pkg::OP_WRITE_VOL);
			end
			default: begin
				lnk_ev = 1'b0;
			end
		endcase
	end

	// bit counter, shift register and opcode live only for one frame
	always_ff @(posedge link_clk_i or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			lnk_cnt_q <= 6'h00;
			lnk_sh_q  <= 34'h0;
			lnk_op_q  <= 8'h00;
		end else begin
			lnk_sh_q <= lnk_sh_d;
			lnk_op_q <= lnk_op_now;
			if (lnk_cnt_q != fslp_pkg::FRM_CNT_MAX) begin
				lnk_cnt_q <= lnk_cnt_q + 6'h01;
			end
		end
	end

	// hold words stay still until the next command, so the core may read them
	always_ff @(posedge link_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			hold_op_q     <= 8'h00;
			hold_addr_q   <= 26'h0;
			hold_data_q   <= 8'h00;
			lnk_req_tgl_q <= 1'b0;
		end else if (lnk_ev) begin
			hold_op_q     <= lnk_op_now;
			hold_addr_q   <= (lnk_cnt_q == fslp_pkg::FRM_DATA_END) ? lnk_sh_d[33:8] :
			                                                         lnk_sh_d[25:0];
			hold_data_q   <= lnk_sh_d[7:0];
			lnk_req_tgl_q <= ~lnk_req_tgl_q;
		end
	end

	// read byte goes out after the dummy byte; 00 if the core has not answered yet
	always_ff @(posedge link_clk_i or negedge frame_rst_n) begin
		if (!frame_rst_n) begin
			lnk_out_q <= 8'h00;
			lnk_oe_q  <= 1'b0;
		end else if (lnk_is_read && lnk_cnt_q == fslp_pkg::FRM_DATA_END) begin
			lnk_out_q <= (lnk_ack_s == lnk_req_tgl_q) ? rdata_q : 8'h00;
			lnk_oe_q  <= 1'b1;
		end else if (lnk_cnt_q == fslp_pkg::FRM_OUT_END) begin
			lnk_oe_q  <= 1'b0;
		end else begin
			lnk_out_q <= {lnk_out_q[6:0], 1'b0};
		end
	end

	assign so_o    = lnk_out_q[7];
	assign so_oe_o = lnk_oe_q;

	// ---------------- core domain ----------------
	logic                         req_s;
	logic                         wp_n_s;
	logic                         seen_q;
	logic                         rsp_tgl_q;
	fslp_pkg::fslp_state_type     state_q;
	fslp_pkg::fslp_state_type     state_d;
	logic                         init_q;
	logic                         wel_q;
	logic                         is_chk_q;
	logic                         rd_pers_q;
	logic [fslp_pkg::IDX_W-1:0]   rd_idx_q;
	logic [9:0]                   chk_blk_q;
	logic [fslp_pkg::IDX_W-1:0]   sweep_idx_q;
	logic                         sweep_pers_q;
	logic [7:0]                   sweep_val_q;
	logic [fslp_pkg::IDX_W-1:0]   hold_idx;
	logic                         hw_lock;
	logic                         idle_free;
	logic                         accept_chk;
	logic                         accept_cmd;
	logic                         data_ok;
	logic                         vol_write_ok;
	logic                         pers_set_ok;
	logic                         pers_clr_ok;
	logic                         vol_all;
	logic                         read_go;
	logic                         vol_we;
	logic                         pers_we;
	logic [fslp_pkg::IDX_W-1:0]   wr_idx;
	logic [7:0]                   vol_wd;
	logic [7:0]                   pers_wd;
	logic [7:0]                   vol_rd;
	logic [7:0]                   pers_rd;
	logic                         check_done_q;
	logic                         check_allowed_q;
	logic                         blocked_q;
	logic                         busy_q;

	fslp_sync2 u_req_sync (
		.clk_i   (ref_clk_i),
		.rst_n_i (resetn_i),
		.d_i     (lnk_req_tgl_q),
		.q_o     (req_s)
	);

	fslp_sync2 u_wp_sync (
		.clk_i   (ref_clk_i),
		.rst_n_i (resetn_i),
		.d_i     (wp_n_i),
		.q_o     (wp_n_s)
	);

	fslp_sync2 u_ack_sync (
		.clk_i   (link_clk_i),
		.rst_n_i (resetn_i),
		.d_i     (rsp_tgl_q),
		.q_o     (lnk_ack_s)
	);

	// command decode; hold words are stable while the request toggle differs
	assign hold_idx     = region_index(hold_addr_q);
	assign hw_lock      = status_protect_select_i & ~wp_n_s;
	assign idle_free    = (state_q == fslp_pkg::ST_IDLE) & ~init_q;
	assign accept_chk   = idle_free & check_req_i;
	assign accept_cmd   = idle_free & ~check_req_i & (req_s ^ seen_q);
	assign data_ok      = (hold_data_q == fslp_pkg::LOCK_CLR) |
	                      (hold_data_q == fslp_pkg::LOCK_SET);
	assign vol_write_ok = accept_cmd & (hold_op_q == fslp_pkg::OP_WRITE_VOL) &
	                      wel_q & data_ok;
	assign pers_set_ok  = accept_cmd & (hold_op_q == fslp_pkg::OP_SET_PERS) &
	                      wel_q & ~hw_lock;
	assign pers_clr_ok  = accept_cmd & (hold_op_q == fslp_pkg::OP_CLEAR_PERS) &
	                      wel_q & ~hw_lock;
	assign vol_all      = accept_cmd & ((hold_op_q == fslp_pkg::OP_VOL_UNLOCK_ALL) |
	                      (hold_op_q == fslp_pkg::OP_VOL_LOCK_ALL));
	assign read_go      = accept_cmd & ((hold_op_q == fslp_pkg::OP_READ_VOL) |
	                      (hold_op_q == fslp_pkg::OP_READ_PERS));

	// sequencer: global commands sweep one region per cycle, 1054 cycles
	always_comb begin
		state_d = state_q;
		case (state_q)
			fslp_pkg::ST_IDLE: begin
				if (init_q || pers_clr_ok || vol_all) begin
					state_d = fslp_pkg::ST_SWEEP;
				end else if (accept_chk || read_go) begin
					state_d = fslp_pkg::ST_FETCH;
				end
			end
			fslp_pkg::ST_FETCH: begin
				state_d = fslp_pkg::ST_RESULT;
			end
			fslp_pkg::ST_RESULT: begin
				state_d = fslp_pkg::ST_IDLE;
			end
			fslp_pkg::ST_SWEEP: begin
				if (sweep_idx_q == fslp_pkg::IDX_LAST) begin
					state_d = fslp_pkg::ST_IDLE;
				end
			end
			default: begin
				state_d = fslp_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_q <= fslp_pkg::ST_IDLE;
			busy_q  <= 1'b1;
		end else begin
			state_q <= state_d;
			busy_q  <= (state_d != fslp_pkg::ST_IDLE);
		end
	end

	// sweep setup; the reset sweep loads the configured volatile default
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			init_q       <= 1'b1;
			sweep_idx_q  <= 11'h000;
			sweep_pers_q <= 1'b0;
			sweep_val_q  <= 8'h00;
		end else if (state_q == fslp_pkg::ST_SWEEP) begin
			sweep_idx_q <= sweep_idx_q + 11'h001;
		end else begin
			sweep_idx_q  <= 11'h000;
			init_q       <= 1'b0;
			sweep_pers_q <= ~init_q & pers_clr_ok;
			if (init_q) begin
				sweep_val_q <= persistent_config_byte2_i[fslp_pkg::CFG_VL_DEFAULT_BIT] ?
				               fslp_pkg::LOCK_SET : fslp_pkg::LOCK_CLR;
			end else begin
				sweep_val_q <= (hold_op_q == fslp_pkg::OP_VOL_LOCK_ALL) ?
				               fslp_pkg::LOCK_SET : fslp_pkg::LOCK_CLR;
			end
		end
	end

	// write enable latch: write disable and accepted volatile writes, persistent sets and persistent clears clear it
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			wel_q <= 1'b0;
		end else if (accept_cmd && hold_op_q == fslp_pkg::OP_WRITE_ENABLE) begin
			wel_q <= 1'b1;
		end else if (accept_cmd && hold_op_q == fslp_pkg::OP_WRITE_DISABLE) begin
			wel_q <= 1'b0;
		end else if (vol_write_ok || pers_set_ok || pers_clr_ok) begin
			wel_q <= 1'b0;
		end
	end

	// request bookkeeping and fetch address
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			seen_q    <= 1'b0;
			is_chk_q  <= 1'b0;
			rd_pers_q <= 1'b0;
			rd_idx_q  <= 11'h000;
			chk_blk_q <= 10'h000;
		end else if (accept_chk) begin
			is_chk_q  <= 1'b1;
			rd_idx_q  <= region_index(check_addr_i);
			chk_blk_q <= check_addr_i[fslp_pkg::ADDR_W-1:fslp_pkg::BLOCK_LSB];
		end else if (accept_cmd) begin
			seen_q    <= req_s;
			is_chk_q  <= 1'b0;
			rd_pers_q <= (hold_op_q == fslp_pkg::OP_READ_PERS);
			rd_idx_q  <= hold_idx;
		end
	end

	// answer to the link: data and the toggle that releases it change on the same edge
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			rdata_q   <= 8'h00;
			rsp_tgl_q <= 1'b0;
		end else if (state_q == fslp_pkg::ST_RESULT && !is_chk_q) begin
			rdata_q   <= rd_pers_q ? pers_rd : vol_rd;
			rsp_tgl_q <= seen_q;
		end else if (state_q == fslp_pkg::ST_IDLE) begin
			rsp_tgl_q <= seen_q;
		end
	end

	// clearance: any of the three schemes protecting the region refuses it
	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			check_done_q    <= 1'b0;
			check_allowed_q <= 1'b0;
			blocked_q       <= 1'b0;
		end else begin
			blocked_q    <= hw_lock;
			check_done_q <= (state_q == fslp_pkg::ST_RESULT) & is_chk_q;
			if (state_q == fslp_pkg::ST_RESULT && is_chk_q) begin
				check_allowed_q <= ~(range_hit(chk_blk_q, range_protect_top_bit_i,
				                     range_protect_code_i, complement_protect_i) |
				                     (vol_rd == fslp_pkg::LOCK_SET) |
				                     (pers_rd == fslp_pkg::LOCK_SET));
			end
		end
	end

	// memory write ports, sweeps own them while running
	assign wr_idx  = (state_q == fslp_pkg::ST_SWEEP) ? sweep_idx_q : hold_idx;
	assign vol_we  = ((state_q == fslp_pkg::ST_SWEEP) & ~sweep_pers_q) | vol_write_ok;
	assign pers_we = ((state_q == fslp_pkg::ST_SWEEP) & sweep_pers_q) | pers_set_ok;
	assign vol_wd  = (state_q == fslp_pkg::ST_SWEEP) ? sweep_val_q : hold_data_q;
	assign pers_wd = (state_q == fslp_pkg::ST_SWEEP) ? sweep_val_q : fslp_pkg::LOCK_SET;

	// two banks of 1054 eight-bit locks, the persistent one unreset
	fslp_lock_mem u_vol_mem (
		.clk_i     (ref_clk_i),
		.wr_en_i   (vol_we),
		.wr_addr_i (wr_idx),
		.wr_data_i (vol_wd),
		.rd_addr_i (rd_idx_q),
		.rd_data_o (vol_rd)
	);

	fslp_lock_mem u_pers_mem (
		.clk_i     (ref_clk_i),
		.wr_en_i   (pers_we),
		.wr_addr_i (wr_idx),
		.wr_data_i (pers_wd),
		.rd_addr_i (rd_idx_q),
		.rd_data_o (pers_rd)
	);

	assign check_done_o           = check_done_q;
	assign check_allowed_o        = check_allowed_q;
	assign write_enable_latch_o   = wel_q;
	assign status_write_blocked_o = blocked_q;
	assign busy_o                 = busy_q;

	// ---------------- checks ----------------
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	wel_clear_a: assert property (vol_write_ok || pers_set_ok || pers_clr_ok |=> !wel_q)
		else $error("latch not cleared after lock write");
	bad_data_a: assert property (accept_cmd && hold_op_q == fslp_pkg::OP_WRITE_VOL && wel_q
		&& !data_ok |-> !vol_we ##1 wel_q)
		else $error("invalid volatile write changed state");
	no_bad_write_a: assert property (vol_we && state_q != fslp_pkg::ST_SWEEP |->
		vol_wd == fslp_pkg::LOCK_CLR || vol_wd == fslp_pkg::LOCK_SET)
		else $error("unsupported volatile lock value written");
	hw_lock_a: assert property (hw_lock && state_q != fslp_pkg::ST_SWEEP |-> !pers_we)
		else $error("persistent lock written while pin locked");
	check_time_a: assert property (accept_chk |-> ##3 check_done_o)
		else $error("clearance answer not three cycles after request");
	range_lock_a: assert property (check_done_o && complement_protect_i
		&& range_protect_top_bit_i && range_protect_code_i == 4'h8
		&& chk_blk_q >= 10'h080 && $stable(range_protect_code_i) |-> !check_allowed_o)
		else $error("complemented range did not protect upper blocks");
	lock_or_a: assert property (state_q == fslp_pkg::ST_RESULT && is_chk_q
		&& (vol_rd == fslp_pkg::LOCK_SET || pers_rd == fslp_pkg::LOCK_SET)
		|=> check_done_o && !check_allowed_o)
		else $error("locked region cleared for program or erase");
	sweep_end_a: assert property (state_q == fslp_pkg::ST_SWEEP
		&& sweep_idx_q == fslp_pkg::IDX_LAST |=> state_q == fslp_pkg::ST_IDLE && !busy_o)
		else $error("sweep did not end at the last region");
	read_reply_a: assert property (state_q == fslp_pkg::ST_RESULT && !is_chk_q
		|=> rdata_q == (rd_pers_q ? $past(pers_rd) : $past(vol_rd)))
		else $error("read reply does not match the addressed lock");
endmodule

//--- fslp_host_model.sv
// fslp_host_model: serial host issuing lock commands, mode 0, msb first
// assumes the device samples si on the rising link edge and shifts so after it
`timescale 1ns/1ps
module fslp_host_model (
	output logic      link_clk_o, // link clock, idles low
	output logic      cs_n_o,     // chip select, low
	output logic      si_o,       // data to device
	input  wire logic so_i,       // data from device
	input  wire logic so_oe_i     // device drives so_i
);
	initial begin
		link_clk_o = 1'b0;
		cs_n_o = 1'b1;
		si_o = 1'b0;
	end
	// one frame: the clock runs only while selected, read bits taken on falling edges
	task automatic frame(input logic [7:0] op, input logic [31:0] a, input logic [7:0] d,
		input int n, output logic [7:0] rd);
		logic [47:0] sh;
		sh = {op, a, d};
		rd = 8'h00;
		cs_n_o = 1'b0;
		for (int i = 0; i < n; i++) begin
			si_o = sh[47];
			sh = {sh[46:0], ~sh[47]};
			#15 link_clk_o = 1'b1;
			#15 link_clk_o = 1'b0;
			if (i >= 47) rd = {rd[6:0], so_oe_i ? so_i : ~so_i}; // undriven line reads inverted
		end
		#15 cs_n_o = 1'b1;
		si_o = ~si_o; // a released line must not look held
	endtask
endmodule

//--- fslp_lock_protect_test.sv
// fslp_lock_protect_test: random and corner checks of range and region locks
// assumes the host model drives the link and this bench drives clearance requests
`timescale 1ns/1ps
module fslp_lock_protect_test;
	logic        ref_clk_i = 1'b0;
	logic        resetn_i = 1'b0;
	logic        top, cmp, req, done, allowed, write_enable_latch, so, lck, cs, si, busy, oe, blk;
	logic        sel = 1'b0;
	logic        wp = 1'b1;
	logic [3:0]  code;
	logic [7:0]  cfg, rd;
	logic [25:0] adr, ra;
	logic [31:0] seed = 32'h1c6a;
	int          mismatches = 0;
	int          checked = 0;
	int          b;
	// core clock, 20 ns
	always #10 ref_clk_i = ~ref_clk_i;
	fslp_host_model host (.link_clk_o(lck), .cs_n_o(cs), .si_o(si), .so_i(so), .so_oe_i(oe));
	fslp_lock_protect dut (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .link_clk_i(lck),
		.cs_n_i(cs), .si_i(si), .so_o(so), .so_oe_o(oe), .range_protect_top_bit_i(top),
		.range_protect_code_i(code), .complement_protect_i(cmp), .status_protect_select_i(sel),
		.wp_n_i(wp), .persistent_config_byte2_i(cfg), .check_req_i(req), .check_addr_i(adr),
		.check_done_o(done), .check_allowed_o(allowed), .write_enable_latch_o(write_enable_latch),
		.status_write_blocked_o(blk), .busy_o(busy));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 1200 && busy !== 1'b0; i++) @(posedge ref_clk_i) #2;
		#2;
	endtask
	// clearance request; done must pulse within a few cycles
	task automatic chk(input logic [25:0] a, input logic exp, input string what);
		wait_idle();
		adr = a;
		req = 1'b1;
		@(posedge ref_clk_i);
		#2 req = 1'b0;
		for (int i = 0; i < 8 && done !== 1'b1; i++) @(posedge ref_clk_i) #2;
		cmp8(what, {6'h0, 1'b1, exp}, {6'h0, done, allowed});
	endtask
	// link frame, then let the core take and finish it
	task automatic cmd(input logic [7:0] op, input logic [25:0] a, input logic [7:0] d, input int n);
		host.frame(op, {6'h0, a}, d, n, rd);
		repeat (8) @(posedge ref_clk_i);
		wait_idle();
	endtask
	// hang guard, well beyond the expected run
	initial begin
		#1000000;
		mismatches++;
		stop_test();
	end
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask
	// main sequence
	initial begin
		{top, cmp, req, code, cfg, adr} = {3'b000, 4'h0, 8'h04, 26'h0};
		repeat (4) @(posedge ref_clk_i);
		#2 resetn_i = 1'b1;
		ra = 26'(rnd() % 1022 + 1) << 16;
		chk(ra, 1'b0, "default lock");
		cmd(fslp_pkg::OP_VOL_UNLOCK_ALL, 0, 0, 8);
		chk(ra, 1'b1, "unlocked");
		{top, cmp} = 2'b11;
		for (int k = 1; k <= 10; k++) begin
			code = 4'(k);
			b = 1 << (k - 1);
			chk((26'(b - 1) << 16) | 26'(rnd() & 32'hffff), 1'b1, "below range");
			chk(26'(b) << 16, 1'b0, "range start");
		end
		cmp = 1'b0;
		chk(26'h3ffffff, 1'b1, "no range");
		code = 4'h0;
		cmd(fslp_pkg::OP_WRITE_ENABLE, 0, 0, 8);
		cmd(fslp_pkg::OP_WRITE_VOL, ra, 8'h55, 48);
		cmp8("latch kept", 8'h01, {7'h0, write_enable_latch});
		cmd(fslp_pkg::OP_WRITE_VOL, ra, 8'hff, 48);
		cmp8("latch cleared", 8'h00, {7'h0, write_enable_latch});
		cmd(fslp_pkg::OP_READ_VOL, ra, 0, 55);
		cmp8("vol read", 8'hff, rd);
		cmd(fslp_pkg::OP_READ_VOL, ra ^ 26'h10000, 0, 55);
		cmp8("vol other", 8'h00, rd);
		chk(ra, 1'b0, "vol locked");
		cmd(fslp_pkg::OP_VOL_LOCK_ALL, 0, 0, 8);
		chk(26'h0004000, 1'b0, "all locked");
		cmd(fslp_pkg::OP_VOL_UNLOCK_ALL, 0, 0, 8);
		cmd(fslp_pkg::OP_WRITE_ENABLE, 0, 0, 8);
		cmd(fslp_pkg::OP_SET_PERS, 26'h3ff3000, 0, 40);
		cmd(fslp_pkg::OP_READ_PERS, 26'h3ff3fff, 0, 55);
		cmp8("pers read", 8'hff, rd);
		cmd(fslp_pkg::OP_READ_PERS, 26'h3ff4000, 0, 55);
		cmp8("pers sector", 8'h00, rd);
		chk(26'h3ff3800, 1'b0, "pers locked");
		{sel, wp} = 2'b10;
		repeat (4) @(posedge ref_clk_i);
		#2 cmp8("pin lock", 8'h01, {7'h0, blk});
		cmd(fslp_pkg::OP_WRITE_ENABLE, 0, 0, 8);
		cmd(fslp_pkg::OP_SET_PERS, 26'h0005000, 0, 40);
		cmd(fslp_pkg::OP_CLEAR_PERS, 0, 0, 8);
		cmp8("latch pin lock", 8'h01, {7'h0, write_enable_latch});
		cmd(fslp_pkg::OP_READ_PERS, 26'h0005000, 0, 55);
		cmp8("pers pin set", 8'h00, rd);
		cmd(fslp_pkg::OP_READ_PERS, 26'h3ff3000, 0, 55);
		cmp8("pers pin clear", 8'hff, rd);
		{sel, wp} = 2'b01;
		repeat (4) @(posedge ref_clk_i);
		#2 cmp8("pin free", 8'h00, {7'h0, blk});
		cmd(fslp_pkg::OP_WRITE_ENABLE, 0, 0, 8);
		cmd(fslp_pkg::OP_CLEAR_PERS, 0, 0, 8);
		cmd(fslp_pkg::OP_READ_PERS, 26'h3ff3000, 0, 55);
		cmp8("pers cleared", 8'h00, rd);
		chk(26'h3ff3000, 1'b1, "pers open");
		stop_test();
	end
endmodule
